// File: gsit_top.sv
// Global status and interrupt tree with APB register access
// What this block does
// R1: Enabled port summary flag drives interrupt low
// R2: Enabled transmit interface summary drives interrupt low
// R3: Enabled global summary drives interrupt low
// R4: Live unlock reads one while any PLL unlocked
// R5: Update done is AND over selected ports
// R6: Software holds update request until done reads one
// R7: Latch 8k reference activity only when selected
// R8: Latch synthesizer reference clock activity
// R9: Latch one-second tick, feeds summary and interrupt
// R10: Latch rising edge of live unlock
// R11: Latch rising edge of live update done
// R12: One-second enable gates its interrupt path
// R13: Unlock enable gates its interrupt path
// R14: Update-done enable gates its interrupt path
// R15: Readback shows level of eight pins
// R16: Port summary set when port status nonzero
// R17: Global summary is OR of enabled latched bits
// R18: Latched bits clear on write one only
// R19: Interrupt is OR of enabled sources, active low
//
// The APB interface to the registers was decided locally.
module gsit_top import gsit_pkg::*; #(
  parameter longint ONE_SEC_CYCLES = GSIT_ONE_SEC_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [GSIT_N_PORTS-1:0] port_isr_nonzero,
  input wire logic tx_sysif_summary_flag,
  input wire logic [GSIT_N_PORTS-1:0] port_perf_update_done,
  input wire logic [GSIT_N_PLL-1:0] synth_pll_unlocked,
  input wire logic synth_ref_clock_pin,
  input wire logic [GSIT_N_GPIO-1:0] gpio_pin,
  output logic irq,
  output logic int_n
);

  typedef struct packed {
    logic [15:0] top_en;
    logic [15:0] lat_en;
    logic [15:0] ctrl;
    logic [GSIT_LAT_W-1:0] lat;
    logic unlock_prev;
    logic done_prev;
    logic [GSIT_SEC_W-1:0] sec_cnt;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
  } gsit_state_t;

  localparam logic [GSIT_SEC_W-1:0] SEC_LAST = GSIT_SEC_W'(ONE_SEC_CYCLES - 1);

  gsit_state_t s_r;
  gsit_state_t s_nxt;

  gsit_sync_if sif ();

  logic apb_setup;
  logic apb_wr;
  logic unlock_live;
  logic done_live;
  logic sec_tick;
  logic glob_flag;
  logic [GSIT_LAT_W-1:0] lat_set;
  logic [GSIT_LAT_W-1:0] lat_clr;
  logic [15:0] top_vec;
  logic [15:0] live_vec;
  logic [15:0] rd_val;
  logic rd_hit;
  logic [GSIT_N_PORTS-1:0] sel_ports;

  // Access-phase write aimed at one register index
  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] idx);
    wr_hit = wr && gsit_hit(a, idx);
  endfunction : wr_hit

  // Pins and the clock synthesizer lock flags are asynchronous to clk
  gsit_pin_sync u_sync (
    .clk(clk),
    .srst(srst),
    .pins_in({synth_pll_unlocked, synth_ref_clock_pin, gpio_pin}),
    .sif(sif)
  );

  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;

  assign unlock_live = |sif.level[GSIT_LANE_PLL +: GSIT_N_PLL]; // [R4]

  // With no port selected the AND is vacuous, so done follows the request alone
  assign sel_ports = s_r.ctrl[GSIT_CTRL_SEL_LSB +: GSIT_N_PORTS];
  assign done_live = s_r.ctrl[GSIT_CTRL_REQ] &
                     (&(port_perf_update_done | ~sel_ports)); // [R5]

  assign sec_tick = (s_r.sec_cnt == SEC_LAST);

  // Activity is seen as a rising edge after synchronising; a reference
  // faster than half of clk will alias but still shows as active
  always_comb begin
    lat_set = '0;
    lat_set[GSIT_LAT_REF8K] = sif.rise[GSIT_LANE_GENERAL_PIN_FOUR] & s_r.ctrl[GSIT_CTRL_REF8K_SEL]; // [R7]
    lat_set[GSIT_LAT_REFCLK] = sif.rise[GSIT_LANE_REFCLK]; // [R8]
    lat_set[GSIT_LAT_ONESEC] = sec_tick; // [R9]
    lat_set[GSIT_LAT_UNLOCK] = unlock_live & ~s_r.unlock_prev; // [R10]
    lat_set[GSIT_LAT_DONE] = done_live & ~s_r.done_prev; // [R11]
  end

  assign lat_clr = (wr_hit(apb_wr, paddr, GSIT_IDX_LATCH) || wr_hit(apb_wr, paddr, GSIT_IDX_CLR))
                   ? pwdata[GSIT_LAT_W-1:0] : '0; // [R18]

  // Only the three enabled latched bits feed the summary
  assign glob_flag = |(s_r.lat[GSIT_LAT_ONESEC:GSIT_LAT_DONE] &
                       s_r.lat_en[GSIT_LAT_ONESEC:GSIT_LAT_DONE]); // [R17] [R12] [R13] [R14]

  always_comb begin
    top_vec = '0;
    top_vec[GSIT_TOP_PORT_LSB +: GSIT_N_PORTS] = port_isr_nonzero; // [R16]
    top_vec[GSIT_TOP_TX] = tx_sysif_summary_flag;
    top_vec[GSIT_TOP_GLOBAL] = glob_flag;
  end

  always_comb begin
    live_vec = '0;
    live_vec[GSIT_LIVE_UNLOCK] = unlock_live;
    live_vec[GSIT_LIVE_DONE] = done_live;
  end

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (gsit_hit(paddr, GSIT_IDX_TOP_STAT)) begin
      rd_val = top_vec;
    end else if (gsit_hit(paddr, GSIT_IDX_TOP_EN)) begin
      rd_val = s_r.top_en;
    end else if (gsit_hit(paddr, GSIT_IDX_LIVE)) begin
      rd_val = live_vec;
    end else if (gsit_hit(paddr, GSIT_IDX_LATCH)) begin
      rd_val = {{(16-GSIT_LAT_W){1'b0}}, s_r.lat};
    end else if (gsit_hit(paddr, GSIT_IDX_LATCH_EN)) begin
      rd_val = s_r.lat_en;
    end else if (gsit_hit(paddr, GSIT_IDX_CTRL)) begin
      rd_val = s_r.ctrl;
    end else if (gsit_hit(paddr, GSIT_IDX_PINS)) begin
      rd_val = {8'h00, sif.level[GSIT_LANE_GPIO +: GSIT_N_GPIO]}; // [R15]
    end else if (gsit_hit(paddr, GSIT_IDX_CLR)) begin
      rd_val = '0;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.unlock_prev = unlock_live;
    s_nxt.done_prev = done_live;
    if (sec_tick) begin
      s_nxt.sec_cnt = '0;
    end else begin
      s_nxt.sec_cnt = s_r.sec_cnt + 1'b1;
    end
    // A new event in the clearing cycle survives the clear
    s_nxt.lat = (s_r.lat & ~lat_clr) | lat_set; // [R18]
    if (wr_hit(apb_wr, paddr, GSIT_IDX_TOP_EN)) begin
      s_nxt.top_en = pwdata[15:0] & GSIT_TOP_EN_MASK;
    end
    if (wr_hit(apb_wr, paddr, GSIT_IDX_LATCH_EN)) begin
      s_nxt.lat_en = pwdata[15:0] & GSIT_LATCH_EN_MASK;
    end
    if (wr_hit(apb_wr, paddr, GSIT_IDX_CTRL)) begin
      s_nxt.ctrl = pwdata[15:0] & GSIT_CTRL_MASK;
    end
    // Read data and error are captured in the setup cycle so they come from flops
    if (apb_setup) begin
      s_nxt.prdata = {16'h0000, rd_val};
      s_nxt.pslverr = ~rd_hit;
    end
    s_nxt.irq = |(top_vec & s_r.top_en); // [R1] [R2] [R3] [R19]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign pready = 1'b1;
  assign irq = s_r.irq;
  assign int_n = ~s_r.irq; // [R19]

  // Helper for the sticky check
  logic [GSIT_LAT_W-1:0] lat_keep;
  assign lat_keep = s_r.lat & ~lat_clr;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_port_irq;
    (|(port_isr_nonzero & s_r.top_en[GSIT_TOP_PORT_LSB +: GSIT_N_PORTS])) |=> !int_n;
  endproperty
  a_port_irq: assert property (p_port_irq) else $error("port source did not pull int_n low"); // [R1]

  // One check per port so a stuck enable bit is pinned to its port
  for (genvar g = 0; g < GSIT_N_PORTS; g++) begin : g_port_chk
    property p_port_each;
      (port_isr_nonzero[g] && s_r.top_en[GSIT_TOP_PORT_LSB + g]) |=> !int_n;
    endproperty
    a_port_each: assert property (p_port_each) else $error("one port left int_n high"); // [R1]
  end

  property p_tx_irq;
    (tx_sysif_summary_flag && s_r.top_en[GSIT_TOP_TX]) |=> !int_n;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx summary did not pull int_n low"); // [R2]

  property p_glob_irq;
    (glob_flag && s_r.top_en[GSIT_TOP_GLOBAL]) |=> !int_n;
  endproperty
  a_glob_irq: assert property (p_glob_irq) else $error("global summary did not pull int_n low"); // [R3]

  property p_unlock_live;
    (synth_pll_unlocked != '0) [*3] |-> live_vec[GSIT_LIVE_UNLOCK];
  endproperty
  a_unlock_live: assert property (p_unlock_live) else $error("live unlock not reported"); // [R4]

  property p_unlock_gone;
    (synth_pll_unlocked == '0) [*3] |-> !live_vec[GSIT_LIVE_UNLOCK];
  endproperty
  a_unlock_gone: assert property (p_unlock_gone) else $error("live unlock stuck high"); // [R4]

  property p_done_no_req;
    !s_r.ctrl[GSIT_CTRL_REQ] |-> !live_vec[GSIT_LIVE_DONE];
  endproperty
  a_done_no_req: assert property (p_done_no_req) else $error("done shown without request"); // [R5]

  property p_done_all_sel;
    (s_r.ctrl[GSIT_CTRL_REQ] && ((port_perf_update_done & sel_ports) == sel_ports))
      |-> live_vec[GSIT_LIVE_DONE];
  endproperty
  a_done_all_sel: assert property (p_done_all_sel) else $error("done missing with ports done"); // [R5]

  property p_ref8k_gate;
    (!s_r.ctrl[GSIT_CTRL_REF8K_SEL] && !s_r.lat[GSIT_LAT_REF8K]) |=> !s_r.lat[GSIT_LAT_REF8K];
  endproperty
  a_ref8k_gate: assert property (p_ref8k_gate) else $error("8k activity latched while unselected"); // [R7]

  // A pin rise needs two sync stages and the edge stage before it latches
  sequence s_ref8k_rise;
    !gpio_pin[GSIT_LANE_GENERAL_PIN_FOUR] ##1 gpio_pin[GSIT_LANE_GENERAL_PIN_FOUR] ##2 s_r.ctrl[GSIT_CTRL_REF8K_SEL];
  endsequence
  property p_ref8k_latch;
    s_ref8k_rise |=> s_r.lat[GSIT_LAT_REF8K];
  endproperty
  a_ref8k_latch: assert property (p_ref8k_latch) else $error("8k activity not latched"); // [R7]

  sequence s_refclk_rise;
    !synth_ref_clock_pin ##1 synth_ref_clock_pin;
  endsequence
  property p_refclk_latch;
    s_refclk_rise |-> ##3 s_r.lat[GSIT_LAT_REFCLK];
  endproperty
  a_refclk_latch: assert property (p_refclk_latch) else $error("ref clock activity missed"); // [R8]

  property p_ones_tick;
    sec_tick |=> (s_r.lat[GSIT_LAT_ONESEC] && s_r.sec_cnt == '0);
  endproperty
  a_ones_tick: assert property (p_ones_tick) else $error("one-second tick not latched"); // [R9]

  property p_ones_summary;
    (s_r.lat[GSIT_LAT_ONESEC] && s_r.lat_en[GSIT_LAT_ONESEC]) |-> top_vec[GSIT_TOP_GLOBAL];
  endproperty
  a_ones_summary: assert property (p_ones_summary) else $error("tick missing from summary"); // [R9]

  property p_unlock_edge;
    $rose(unlock_live) |=> s_r.lat[GSIT_LAT_UNLOCK];
  endproperty
  a_unlock_edge: assert property (p_unlock_edge) else $error("unlock rise not latched"); // [R10]

  property p_done_edge;
    $rose(done_live) |=> s_r.lat[GSIT_LAT_DONE];
  endproperty
  a_done_edge: assert property (p_done_edge) else $error("update done rise not latched"); // [R11]

  sequence s_tick_armed;
    sec_tick && s_r.lat_en[GSIT_LAT_ONESEC] && s_r.top_en[GSIT_TOP_GLOBAL] && !apb_wr;
  endsequence
  sequence s_bus_quiet;
    !apb_wr;
  endsequence
  property p_ones_irq;
    s_tick_armed ##1 s_bus_quiet |=> !int_n;
  endproperty
  a_ones_irq: assert property (p_ones_irq) else $error("tick gave no interrupt"); // [R12]

  sequence s_unlock_armed;
    $rose(unlock_live) && s_r.lat_en[GSIT_LAT_UNLOCK] && s_r.top_en[GSIT_TOP_GLOBAL] && !apb_wr;
  endsequence
  property p_unlock_irq;
    s_unlock_armed ##1 s_bus_quiet |=> !int_n;
  endproperty
  a_unlock_irq: assert property (p_unlock_irq) else $error("unlock event gave no interrupt"); // [R13]

  property p_done_masked;
    (!s_r.lat_en[GSIT_LAT_DONE] && !s_r.lat_en[GSIT_LAT_ONESEC] && !s_r.lat_en[GSIT_LAT_UNLOCK])
      |-> !glob_flag;
  endproperty
  a_done_masked: assert property (p_done_masked) else $error("summary set with enables off"); // [R14]

  property p_glob_clear;
    !(|(s_r.lat[GSIT_LAT_ONESEC:GSIT_LAT_DONE] & s_r.lat_en[GSIT_LAT_ONESEC:GSIT_LAT_DONE]))
      |-> !top_vec[GSIT_TOP_GLOBAL];
  endproperty
  a_glob_clear: assert property (p_glob_clear) else $error("summary set with nothing enabled"); // [R17]

  property p_port_flag;
    top_vec[GSIT_TOP_PORT_LSB +: GSIT_N_PORTS] == port_isr_nonzero;
  endproperty
  a_port_flag: assert property (p_port_flag) else $error("port summary flag wrong"); // [R16]

  // Write-one clear takes the bit away unless a new event lands at once
  sequence s_clear_tick;
    wr_hit(apb_wr, paddr, GSIT_IDX_LATCH) && pwdata[GSIT_LAT_ONESEC] && !sec_tick;
  endsequence
  property p_clear_w1;
    s_clear_tick |=> !s_r.lat[GSIT_LAT_ONESEC];
  endproperty
  a_clear_w1: assert property (p_clear_w1) else $error("write one did not clear"); // [R18]

  property p_sticky;
    1'b1 |=> ((s_r.lat & $past(lat_keep)) == $past(lat_keep));
  endproperty
  a_sticky: assert property (p_sticky) else $error("latched bit lost without a clear"); // [R18]

  property p_irq_release;
    (!(|(top_vec & s_r.top_en))) |=> int_n;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("int_n low with no source"); // [R19]

  property p_err_unmapped;
    (apb_setup && !rd_hit) |=> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access gave no error");

  // Read data must stand through the access phase
  property p_rd_hold;
    !apb_setup |=> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside setup");

endmodule : gsit_top

// File: gsit_pkg.sv
// Package: register indices, field positions, reset values and timing for the interrupt tree
package gsit_pkg;

  // Register indices; byte address on APB is four times the index
  localparam logic [7:0] GSIT_IDX_TOP_STAT = 8'h10;
  localparam logic [7:0] GSIT_IDX_TOP_EN = 8'h12;
  localparam logic [7:0] GSIT_IDX_LIVE = 8'h14;
  localparam logic [7:0] GSIT_IDX_LATCH = 8'h16;
  localparam logic [7:0] GSIT_IDX_LATCH_EN = 8'h18;
  localparam logic [7:0] GSIT_IDX_CTRL = 8'h1A;
  localparam logic [7:0] GSIT_IDX_PINS = 8'h1C;
  localparam logic [7:0] GSIT_IDX_CLR = 8'h1E;

  localparam int GSIT_N_PORTS = 4;
  localparam int GSIT_N_GPIO = 8;
  localparam int GSIT_N_PLL = 3;
  localparam int GSIT_LAT_W = 5;

  // Top-level status and enable fields
  localparam int GSIT_TOP_GLOBAL = 0;
  localparam int GSIT_TOP_TX = 1;
  localparam int GSIT_TOP_PORT_LSB = 4;

  // Live status fields
  localparam int GSIT_LIVE_DONE = 0;
  localparam int GSIT_LIVE_UNLOCK = 1;

  // Latched status fields
  localparam int GSIT_LAT_DONE = 0;
  localparam int GSIT_LAT_UNLOCK = 1;
  localparam int GSIT_LAT_ONESEC = 2;
  localparam int GSIT_LAT_REFCLK = 3;
  localparam int GSIT_LAT_REF8K = 4;

  // Control register fields
  localparam int GSIT_CTRL_REQ = 0;
  localparam int GSIT_CTRL_SEL_LSB = 4;
  localparam int GSIT_CTRL_REF8K_SEL = 8;

  // Writable bit masks and reset values
  localparam logic [15:0] GSIT_TOP_EN_MASK = 16'h00F3;
  localparam logic [15:0] GSIT_LATCH_EN_MASK = 16'h0007;
  localparam logic [15:0] GSIT_CTRL_MASK = 16'h01F1;
  localparam logic [15:0] GSIT_REG_RST = 16'h0000;

  // Synchroniser lane map
  localparam int GSIT_SYNC_W = 12;
  localparam int GSIT_LANE_GPIO = 0;
  localparam int GSIT_LANE_GENERAL_PIN_FOUR = 3;
  localparam int GSIT_LANE_REFCLK = 8;
  localparam int GSIT_LANE_PLL = 9;

  // One-second tick
  localparam longint GSIT_CLK_PERIOD_NS = 10;
  localparam longint GSIT_ONE_SECOND_MS = 1000;
  localparam longint GSIT_ONE_SEC_CYCLES = GSIT_ONE_SECOND_MS * 1000000 / GSIT_CLK_PERIOD_NS;
  localparam int GSIT_SEC_W = 27;

  // True when a byte address selects the given register index
  function automatic logic gsit_hit(input logic [7:0] paddr, input logic [7:0] idx);
    gsit_hit = (paddr == {idx[5:0], 2'b00});
  endfunction : gsit_hit

endpackage : gsit_pkg

// File: gsit_sync_if.sv
// Interface: synchronised pin levels and rising-edge pulses
interface gsit_sync_if import gsit_pkg::*; ();
  logic [GSIT_SYNC_W-1:0] level;
  logic [GSIT_SYNC_W-1:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface : gsit_sync_if

// File: gsit_pin_sync.sv
// Two-flop synchronisers with rising-edge detect for all asynchronous inputs
module gsit_pin_sync import gsit_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic [GSIT_SYNC_W-1:0] pins_in,
  gsit_sync_if.src sif
);

  typedef struct packed {
    logic [GSIT_SYNC_W-1:0] meta;
    logic [GSIT_SYNC_W-1:0] stable;
    logic [GSIT_SYNC_W-1:0] prev;
  } gsit_sync_state_t;

  gsit_sync_state_t s_r;
  gsit_sync_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = pins_in;
    s_nxt.stable = s_r.meta;
    s_nxt.prev = s_r.stable;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Edge detect looks only at the second and third stages, never the first
  assign sif.level = s_r.stable;
  assign sif.rise = s_r.stable & ~s_r.prev;

endmodule : gsit_pin_sync

// File: tb.sv
// Self-checking bench for the global status and interrupt tree
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gsit_pkg::*;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] pnz = 4'h0;
  logic tx_sum = 1'b0;
  logic [3:0] pdone = 4'h0;
  logic [2:0] pll = 3'h0;
  logic refclk = 1'b0;
  logic [7:0] gpio = 8'h00;
  logic irq;
  logic int_n;
  int num_errors = 0;
  int compares = 0;
  int seed = 20;
  logic [31:0] r;
  logic [31:0] rd;
  logic err;
  logic [15:0] en;

  // One-second period shortened so the tick shows up in a short run
  gsit_top #(.ONE_SEC_CYCLES(50)) u_dut (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_isr_nonzero(pnz),
    .tx_sysif_summary_flag(tx_sum), .port_perf_update_done(pdone), .synth_pll_unlocked(pll),
    .synth_ref_clock_pin(refclk), .gpio_pin(gpio), .irq(irq), .int_n(int_n));

  initial begin
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] ba(input logic [7:0] idx);
    ba = {idx[5:0], 2'b00};
  endfunction : ba

  task automatic results;
    $display("Comparisons %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Full APB transfer; the request stands until pready is seen at an access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, ba(idx), d);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, ba(idx), 32'h0);
    chk(rd & m, exp & m, "register read");
  endtask : rdchk

  task automatic settle;
    repeat (4) @(posedge clk);
  endtask : settle

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rdchk(GSIT_IDX_TOP_EN, 32'h0, 32'hFFFFFFFF);
    rdchk(GSIT_IDX_LATCH_EN, 32'h0, 32'hFFFFFFFF);
    chk({31'h0, int_n}, 32'h1, "idle interrupt pin");
    apb(1'b0, 8'h04, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped address error");
    // Random port and transmit summaries against random top-level enables
    for (int i = 0; i < 10; i++) begin
      r = $random(seed);
      pnz <= r[3:0];
      tx_sum <= r[4];
      en = r[23:8] & GSIT_TOP_EN_MASK;
      wr(GSIT_IDX_TOP_EN, {16'h0, en});
      settle();
      rdchk(GSIT_IDX_TOP_STAT, {24'h0, pnz, 2'b00, tx_sum, 1'b0}, 32'hFFFF);
      chk({31'h0, int_n}, {31'h0, ~|({pnz, 2'b00, tx_sum, 1'b0} & en[7:0])}, "int pin");
    end
    pnz <= 4'h0;
    tx_sum <= 1'b0;
    r = $random(seed);
    gpio <= r[7:0];
    settle();
    rdchk(GSIT_IDX_PINS, {24'h0, r[7:0]}, 32'hFFFF);
    // Unlock path: live bit, edge latch, write-one clear and enables
    wr(GSIT_IDX_TOP_EN, 32'h1);
    wr(GSIT_IDX_LATCH, 32'h1F);
    rdchk(GSIT_IDX_LATCH, 32'h0, 32'h1B);
    pll <= 3'b010;
    settle();
    rdchk(GSIT_IDX_LIVE, 32'h2, 32'h2);
    rdchk(GSIT_IDX_LATCH, 32'h2, 32'h1B);
    wr(GSIT_IDX_LATCH, 32'h0);
    rdchk(GSIT_IDX_LATCH, 32'h2, 32'h1B);
    chk({31'h0, int_n}, 32'h1, "unlock masked");
    wr(GSIT_IDX_LATCH_EN, 32'h2);
    settle();
    chk({31'h0, int_n}, 32'h0, "unlock enabled");
    rdchk(GSIT_IDX_TOP_STAT, 32'h1, 32'h1);
    wr(GSIT_IDX_LATCH, 32'h2);
    settle();
    chk({31'h0, int_n}, 32'h1, "unlock cleared");
    // A fresh loss of lock with the global summary and unlock enables already set
    pll <= 3'b000;
    settle();
    pll <= 3'b100;
    settle();
    settle();
    chk({31'h0, int_n}, 32'h0, "unlock armed");
    wr(GSIT_IDX_LATCH, 32'h2);
    pll <= 3'b000;
    // Update-done is the AND over the selected ports only
    wr(GSIT_IDX_CTRL, 32'h51);
    pdone <= 4'b1011;
    settle();
    rdchk(GSIT_IDX_LIVE, 32'h0, 32'h1);
    pdone <= 4'b0101;
    settle();
    rdchk(GSIT_IDX_LIVE, 32'h1, 32'h1);
    rdchk(GSIT_IDX_LATCH, 32'h1, 32'h1);
    wr(GSIT_IDX_LATCH_EN, 32'h1);
    settle();
    chk({31'h0, int_n}, 32'h0, "update done enabled");
    wr(GSIT_IDX_TOP_EN, 32'h0);
    settle();
    chk({31'h0, int_n}, 32'h1, "summary disabled");
    wr(GSIT_IDX_CTRL, 32'h0);
    rdchk(GSIT_IDX_LIVE, 32'h0, 32'h1);
    pdone <= 4'h0;
    // One-second tick with its enable
    wr(GSIT_IDX_TOP_EN, 32'h1);
    wr(GSIT_IDX_LATCH_EN, 32'h4);
    repeat (60) @(posedge clk);
    rdchk(GSIT_IDX_LATCH, 32'h4, 32'h4);
    chk({31'h0, int_n}, 32'h0, "one second enabled");
    wr(GSIT_IDX_LATCH_EN, 32'h0);
    settle();
    chk({31'h0, int_n}, 32'h1, "one second masked");
    // Reference activity; the 8k pin only counts once selected
    wr(GSIT_IDX_LATCH, 32'h18);
    for (int i = 0; i < 8; i++) begin
      refclk <= ~refclk;
      gpio[3] <= ~gpio[3];
      settle();
    end
    rdchk(GSIT_IDX_LATCH, 32'h08, 32'h18);
    wr(GSIT_IDX_CTRL, 32'h100);
    for (int i = 0; i < 8; i++) begin
      gpio[3] <= ~gpio[3];
      settle();
    end
    rdchk(GSIT_IDX_LATCH, 32'h10, 32'h10);
    results();
  end
endmodule : tb
